// file: core/tsic_device.sv
// Purpose: device end: decodes control bytes into matrix settings, runs the frame
// Assumes: link pins are asynchronous to clk and pass three flip-flops
// Notes: conversion result comes from sample_data, the analog core sits outside
`include "tsic_map.svh"
// Behaviour
// R1: select bit 1 single-ended, 0 differential
// R2: single-ended position and pressure drivers per code
// R3: temp, battery, aux codes switch no drivers
// R4: differential position ties references to plates
// R5: single-ended uses reference pin versus ground
// R6: single-ended plate bias off after acquisition
// R7: differential keeps drivers on whole conversion
// R8: pen irq low on touch when enabled
// R9: host ignores pen irq after chip select
// R10: pen irq valid after last bit or deselect
// R11: battery channel divides input by four
// R12: battery divider only during battery sampling
// R13: reference power bit switches internal reference
// R14: internal reference for non-ratiometric channels
// R15: temperature always uses internal reference
// R16: host waits ten milliseconds after reference on
// R17: host clears reference bit to turn off
// R18: host clears reference bit for ratiometric
// R19: temperature codes pick low or high bias
// R20: control byte field layout
// R21: power modes gate pen detect and converter
// R22: differential pressure codes mirror single-ended
module tsic_device (
  tsic_link_if.device link,
  input wire logic clk,
  input wire logic rst_b,
  input wire logic touch_detected,
  input wire logic [11:0] sample_data,
  output logic [3:0] plate_drv_r,
  output tsic_pkg::tsic_in_type adc_in_r,
  output tsic_pkg::tsic_ref_type adc_ref_r,
  output logic bat_div_en_r,
  output logic int_ref_en_r,
  output logic conv_power_r,
  output logic temp_high_bias_r,
  output logic sampling_r
);
  import tsic_pkg::*;
  // plate driver bits: 3 x plus, 2 x minus, 1 y plus, 0 y minus
  logic [2:0] cs_s_r, clk_s_r, din_s_r;
  logic cs_q, clk_q, din_q, clk_prev_r;
  tsic_dev_state_type state_r, state_nxt;
  logic [7:0] shift_r;
  logic [7:0] ctrl_r;
  logic [4:0] cnt_r;
  logic [11:0] out_r;
  logic dout_r, busy_r;
  logic pen_free_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_s_r <= 3'h7;
      clk_s_r <= 3'h0;
      din_s_r <= 3'h0;
    end else begin
      cs_s_r <= {cs_s_r[1:0], link.cs_b};
      clk_s_r <= {clk_s_r[1:0], link.serial_shift_clock};
      din_s_r <= {din_s_r[1:0], link.din};
    end
  end
  // change counts only when the last two stages agree, filtering one-stage glitches
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_q <= 1'b1;
      clk_q <= 1'b0;
      din_q <= 1'b0;
    end else begin
      if (cs_s_r[1] == cs_s_r[2]) cs_q <= cs_s_r[2];
      if (clk_s_r[1] == clk_s_r[2]) clk_q <= clk_s_r[2];
      if (din_s_r[1] == din_s_r[2]) din_q <= din_s_r[2];
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) clk_prev_r <= 1'b0;
    else clk_prev_r <= clk_q;
  end
  // a pin edge reaches rise or fall about four clocks late, so dout for one falling edge
  // is on the wire only after the host's next rising edge; the host reads it a period later
  wire sel = ~cs_q;
  wire rise = sel & clk_q & ~clk_prev_r;
  wire fall = sel & ~clk_q & clk_prev_r;
  // control byte fields
  wire [2:0] ch = ctrl_r[`TSIC_BIT_CH_HI:`TSIC_BIT_CH_LO]; // see R20
  wire single = ctrl_r[`TSIC_BIT_SGL]; // see R1
  wire refpwr = ctrl_r[`TSIC_BIT_REFPWR]; // see R13
  wire convpwr = ctrl_r[`TSIC_BIT_CONVPWR];
  wire [4:0] nbits = ctrl_r[`TSIC_BIT_RES12] ? `TSIC_RES12_BITS : `TSIC_RES8_BITS;
  // pen detect only in the full power-down mode
  wire pen_en = ~refpwr & ~convpwr; // see R21
  wire in_conv = (state_r == TSIC_DEV_CONV);
  wire acq = in_conv & (cnt_r == 5'h0);
  wire is_bat = single & (ch == `TSIC_CH_BAT);
  wire is_temp = (ch == `TSIC_CH_TEMP_LO) | (ch == `TSIC_CH_TEMP_HI); // see R15
  // matrix decode: driver set per code, identical for pressure in both modes
  logic [3:0] drv_sel;
  tsic_in_type in_sel;
  tsic_ref_type ref_sel;
  always_comb begin
    drv_sel = 4'h0;
    in_sel = TSIC_IN_XP;
    case (ch)
      `TSIC_CH_YPOS: begin drv_sel = 4'h3; in_sel = TSIC_IN_XP; end // see R2
      `TSIC_CH_Z1: begin drv_sel = 4'h6; in_sel = TSIC_IN_XP; end // see R2, see R22
      `TSIC_CH_Z2: begin drv_sel = 4'h6; in_sel = TSIC_IN_YM; end // see R2, see R22
      `TSIC_CH_XPOS: begin drv_sel = 4'hc; in_sel = TSIC_IN_YP; end // see R2, see R4
      `TSIC_CH_BAT: in_sel = TSIC_IN_BAT; // see R3
      `TSIC_CH_AUX: in_sel = TSIC_IN_AUX; // see R3
      default: in_sel = TSIC_IN_TEMP; // see R3, see R19
    endcase
    // differential pressure keeps the pin reference; no plate pair is named for it
    if (!single && ch == `TSIC_CH_YPOS) ref_sel = TSIC_REF_YPLATE; // see R4
    else if (!single && ch == `TSIC_CH_XPOS) ref_sel = TSIC_REF_XPLATE; // see R4
    else if (is_temp) ref_sel = TSIC_REF_INT; // see R15
    else if (single && refpwr) ref_sel = TSIC_REF_INT; // see R14
    else ref_sel = TSIC_REF_PIN; // see R5
  end
  // single-ended drops bias after acquisition to save power; differential holds it
  wire drv_on = in_conv & (acq | ~single); // see R6, see R7
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      TSIC_DEV_IDLE: if (rise && din_q) state_nxt = TSIC_DEV_CMD;
      TSIC_DEV_CMD: if (fall && cnt_r == 5'h8) state_nxt = TSIC_DEV_CONV;
      TSIC_DEV_CONV: if (fall && cnt_r == nbits) state_nxt = TSIC_DEV_IDLE;
      default: state_nxt = TSIC_DEV_IDLE;
    endcase
    if (cs_q) state_nxt = TSIC_DEV_IDLE;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= TSIC_DEV_IDLE;
      cnt_r <= 5'h0;
      shift_r <= 8'h00;
      ctrl_r <= 8'h00;
      out_r <= 12'h000;
      dout_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_r == TSIC_DEV_IDLE && rise && din_q) begin
        shift_r <= 8'h01;
        cnt_r <= 5'h1;
      end else if (state_r == TSIC_DEV_CMD && rise) begin
        shift_r <= {shift_r[6:0], din_q};
      end else if (state_r == TSIC_DEV_CMD && fall && cnt_r != 5'h8) begin
        cnt_r <= cnt_r + 5'h1;
      end else if (state_r == TSIC_DEV_CMD && fall) begin
        ctrl_r <= shift_r;
        cnt_r <= 5'h0;
        busy_r <= 1'b1;
        out_r <= sample_data;
      end else if (in_conv && fall && cnt_r == nbits) begin
        // trailing bits read as zero, which also pads an 8-bit result
        dout_r <= 1'b0;
        cnt_r <= 5'h0;
      end else if (in_conv && fall) begin
        busy_r <= 1'b0;
        dout_r <= out_r[11];
        out_r <= {out_r[10:0], 1'b0};
        cnt_r <= cnt_r + 5'h1;
      end
      // deselect aborts any frame; a frame cut before the control byte is complete leaves ctrl_r as it was
      if (cs_q) begin
        busy_r <= 1'b0;
        cnt_r <= 5'h0;
      end
    end
  end
  // irq masked from select until last bit out or deselect; a new start bit masks it again
  // channel switching in a frame may pull the line, so it stays released while masked
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) pen_free_r <= 1'b0;
    else if (cs_q || (state_r == TSIC_DEV_IDLE && rise && din_q)) pen_free_r <= 1'b0;
    else if (in_conv && fall && cnt_r == nbits) pen_free_r <= 1'b1; // see R10
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      plate_drv_r <= 4'h0;
      adc_in_r <= TSIC_IN_XP;
      adc_ref_r <= TSIC_REF_PIN;
      bat_div_en_r <= 1'b0;
      int_ref_en_r <= 1'b0;
      conv_power_r <= 1'b0;
      temp_high_bias_r <= 1'b0;
      sampling_r <= 1'b0;
      link.pen_touch_irq_n_oe <= 1'b0;
      link.dout <= 1'b0;
      link.busy <= 1'b0;
    end else begin
      plate_drv_r <= drv_on ? drv_sel : 4'h0;
      adc_in_r <= in_sel;
      adc_ref_r <= ref_sel;
      bat_div_en_r <= acq & is_bat; // see R11, see R12
      int_ref_en_r <= refpwr | (in_conv & is_temp); // see R13, see R15
      conv_power_r <= convpwr | in_conv; // see R21
      temp_high_bias_r <= (ch == `TSIC_CH_TEMP_HI); // see R19
      sampling_r <= acq;
      link.pen_touch_irq_n_oe <= pen_en & touch_detected & (~sel | pen_free_r); // see R8, see R9
      link.dout <= dout_r & sel;
      link.busy <= busy_r & sel;
    end
  end
endmodule

// file: core/tsic_host.sv
// Purpose: host end: sends a control byte and reads the result over the link
// Assumes: software writes orders over Avalon-MM, one word per register
// Notes: shift clock derived from clk by a divider; 24 clocks a frame
`include "tsic_map.svh"
module tsic_host (
  tsic_link_if.host link,
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  import tsic_pkg::*;
  tsic_hst_state_type state_r;
  logic [7:0] ctrl_r, div_r;
  logic [23:0] tx_r;
  logic [23:0] rx_r;
  logic [4:0] bit_r;
  logic sck_r, cs_r, done_r, ack_r;
  logic [2:0] pen_s_r;
  logic pen_q;
  // a write lands on the edge that completes the transfer
  wire wr_ctrl = avs_write & (avs_address == `TSIC_REG_CTRL) & ack_r;
  wire busy = (state_r != TSIC_HST_IDLE);
  wire tick = (div_r == `TSIC_CLK_DIV - 8'h01);
  // pen line only trusted while deselected; conversion may glitch it
  wire pen_seen = ~pen_q & ~busy; // see R9
  wire [31:0] rd_mux = (avs_address == `TSIC_REG_CTRL) ? {24'h0000_00, ctrl_r} :
                       (avs_address == `TSIC_REG_STAT) ? {29'h0000_0000, pen_seen, done_r, busy} :
                       (avs_address == `TSIC_REG_RESULT) ? {20'h0000_0, rx_r[13:2]} : 32'h0000_0000;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) pen_s_r <= 3'h7;
    else pen_s_r <= {pen_s_r[1:0], link.pen_touch_irq_n_line};
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) pen_q <= 1'b1;
    else if (pen_s_r[1] == pen_s_r[2]) pen_q <= pen_s_r[2];
  end
  // one wait cycle, answer on the following edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_r <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      avs_waitrequest <= 1'b1;
    end else begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
      avs_waitrequest <= ~((avs_read | avs_write) & ~ack_r);
      avs_readdata <= rd_mux;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= TSIC_HST_IDLE;
      ctrl_r <= 8'h00;
      tx_r <= 24'h0000_00;
      rx_r <= 24'h0000_00;
      bit_r <= 5'h0;
      div_r <= 8'h00;
      sck_r <= 1'b0;
      cs_r <= 1'b1;
      done_r <= 1'b0;
    end else begin
      case (state_r)
        TSIC_HST_IDLE: begin
          if (wr_ctrl && !busy) begin
            // start bit forced so every order starts a frame; see R20
            ctrl_r <= avs_writedata[7:0] | 8'h80; // see R17, see R18
            tx_r <= {avs_writedata[7:0] | 8'h80, 16'h0000};
            cs_r <= 1'b0;
            bit_r <= 5'h0;
            div_r <= 8'h00;
            done_r <= 1'b0;
            state_r <= TSIC_HST_SHIFT;
          end
        end
        TSIC_HST_SHIFT: begin
          div_r <= tick ? 8'h00 : div_r + 8'h01;
          if (tick) begin
            sck_r <= ~sck_r;
            if (sck_r) begin
              tx_r <= {tx_r[22:0], 1'b0};
              bit_r <= bit_r + 5'h1;
              if (bit_r == 5'd23) state_r <= TSIC_HST_DONE;
            end else begin
              rx_r <= {rx_r[22:0], link.dout};
            end
          end
        end
        TSIC_HST_DONE: begin
          cs_r <= 1'b1;
          done_r <= 1'b1;
          state_r <= TSIC_HST_IDLE;
        end
        default: state_r <= TSIC_HST_IDLE;
      endcase
      // only a done that the read has reported is cleared, so a frame ending meanwhile is kept
      if (avs_read && ack_r && avs_address == `TSIC_REG_STAT && avs_readdata[1]) done_r <= 1'b0;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      link.cs_b <= 1'b1;
      link.serial_shift_clock <= 1'b0;
      link.din <= 1'b0;
    end else begin
      link.cs_b <= cs_r;
      link.serial_shift_clock <= sck_r;
      link.din <= tx_r[23];
    end
  end
endmodule

// file: core/tsic_link_if.sv
// Purpose: serial control link between host and touch converter control
// Assumes: chip select and shift clock are made by the host
// Notes: pen request is open drain; the wire is low when enable is high
interface tsic_link_if;
  logic cs_b;
  logic serial_shift_clock;
  logic din;
  logic dout;
  logic busy;
  logic pen_touch_irq_n_oe;
  wire pen_touch_irq_n_line = ~pen_touch_irq_n_oe;
  modport device (input cs_b, input serial_shift_clock, input din, output dout, output busy,
    output pen_touch_irq_n_oe, input pen_touch_irq_n_line);
  modport host (output cs_b, output serial_shift_clock, output din, input dout, input busy,
    input pen_touch_irq_n_line);
endinterface

// file: core/tsic_map.svh
// Purpose: constants for the touch input matrix control and its serial link
// Assumes: 10 MHz system clock on both ends
// Notes: control byte layout and channel codes
`ifndef TSIC_MAP_SVH
`define TSIC_MAP_SVH
`define TSIC_BIT_START 7
`define TSIC_BIT_CH_HI 6
`define TSIC_BIT_CH_LO 4
`define TSIC_BIT_RES12 3
`define TSIC_BIT_SGL 2
`define TSIC_BIT_REFPWR 1
`define TSIC_BIT_CONVPWR 0
`define TSIC_CH_TEMP_LO 3'h0
`define TSIC_CH_YPOS 3'h1
`define TSIC_CH_BAT 3'h2
`define TSIC_CH_Z1 3'h3
`define TSIC_CH_Z2 3'h4
`define TSIC_CH_XPOS 3'h5
`define TSIC_CH_AUX 3'h6
`define TSIC_CH_TEMP_HI 3'h7
`define TSIC_CLK_DIV 8'h04
`define TSIC_RES12_BITS 5'h0c
`define TSIC_RES8_BITS 5'h08
`define TSIC_ACQ_END_FALL 5'h08
`define TSIC_REG_CTRL 4'h0
`define TSIC_REG_STAT 4'h4
`define TSIC_REG_RESULT 4'h8
`define TSIC_REG_MATRIX 4'hc
`endif

// file: core/tsic_pkg.sv
// Purpose: shared types for the touch input matrix control
// Assumes: nothing beyond the map header
// Notes: mux input and reference selections
package tsic_pkg;
  typedef enum logic [2:0] {
    TSIC_IN_XP = 3'h0, TSIC_IN_YP = 3'h1, TSIC_IN_YM = 3'h2, TSIC_IN_BAT = 3'h3,
    TSIC_IN_AUX = 3'h4, TSIC_IN_TEMP = 3'h5
  } tsic_in_type;
  typedef enum logic [1:0] {
    TSIC_REF_PIN = 2'h0, TSIC_REF_INT = 2'h1, TSIC_REF_YPLATE = 2'h2, TSIC_REF_XPLATE = 2'h3
  } tsic_ref_type;
  typedef enum logic [2:0] {
    TSIC_DEV_IDLE = 3'h0, TSIC_DEV_CMD = 3'h1, TSIC_DEV_CONV = 3'h3, TSIC_DEV_TAIL = 3'h2
  } tsic_dev_state_type;
  typedef enum logic [2:0] {
    TSIC_HST_IDLE = 3'h0, TSIC_HST_SHIFT = 3'h1, TSIC_HST_DONE = 3'h3
  } tsic_hst_state_type;
endpackage

// file: tb/touch_adc_input_matrix_control_tb_top.sv
// Purpose: host and device ends joined by the link, driven from the register bus
// Assumes: clk 100 ns, host makes the 800 ns shift clock
// Notes: differential pressure reference is left open, its drivers and input are still checked
module touch_adc_input_matrix_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import tsic_pkg::*;
  logic clk, rst_b, touch_detected, bat_div_en_r, int_ref_en_r, conv_power_r, temp_high_bias_r, sampling_r;
  logic [11:0] sample_data;
  logic [3:0] plate_drv_r, avs_address;
  tsic_in_type adc_in_r;
  tsic_ref_type adc_ref_r;
  logic avs_read, avs_write, avs_waitrequest, cs_q, sck_q;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [10:0] cap;
  logic [23:0] shi, sho;
  logic [7:0] b;
  int bad_count, cmp_count, cyc, samp_cnt, drv_cnt, k;
  tsic_link_if link ();
  tsic_device u_tsic_device (.link(link), .clk(clk), .rst_b(rst_b), .touch_detected(touch_detected),
    .sample_data(sample_data), .plate_drv_r(plate_drv_r), .adc_in_r(adc_in_r), .adc_ref_r(adc_ref_r),
    .bat_div_en_r(bat_div_en_r), .int_ref_en_r(int_ref_en_r), .conv_power_r(conv_power_r),
    .temp_high_bias_r(temp_high_bias_r), .sampling_r(sampling_r));
  tsic_host u_tsic_host (.link(link), .clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  tsic_link_asserts u_tsic_link_asserts (.clk(clk), .rst_b(rst_b), .cs_b(link.cs_b), .dout(link.dout),
    .busy(link.busy), .pen_touch_irq_n_oe(link.pen_touch_irq_n_oe), .touch_detected(touch_detected),
    .plate_drv_r(plate_drv_r), .adc_in_r(adc_in_r), .adc_ref_r(adc_ref_r), .bat_div_en_r(bat_div_en_r),
    .sampling_r(sampling_r));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // frame monitor: the last acquisition settings and the bits seen on the wire
  always @(posedge clk) begin
    cs_q <= link.cs_b;
    sck_q <= link.serial_shift_clock;
    if (cs_q && !link.cs_b) begin
      samp_cnt <= 0;
      drv_cnt <= 0;
    end else begin
      if (sampling_r) samp_cnt <= samp_cnt + 1;
      if (sampling_r) cap <= {plate_drv_r, adc_in_r, adc_ref_r, bat_div_en_r, temp_high_bias_r};
      if (plate_drv_r != 4'h0) drv_cnt <= drv_cnt + 1;
    end
    if (!link.cs_b && link.serial_shift_clock && !sck_q) begin
      shi <= {shi[22:0], link.din};
      sho <= {sho[22:0], link.dout};
    end
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t word got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_cfg(input logic [10:0] got, input logic [10:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t matrix got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n == 50) chk_word(32'h0000_0001, 32'h0000_0000);
    @(posedge clk);
  endtask
  // drivers as {x+,x-,y+,y-}; single-ended reference follows the reference power bit except on temperature
  function automatic logic [10:0] exp_cfg(input logic [7:0] c);
    logic [3:0] d;
    tsic_in_type i;
    tsic_ref_type r;
    d = 4'h0;
    r = (c[2] && c[1]) ? TSIC_REF_INT : TSIC_REF_PIN;
    case (c[6:4])
      3'h0, 3'h7: begin i = TSIC_IN_TEMP; r = TSIC_REF_INT; end
      3'h1: begin i = TSIC_IN_XP; d = 4'h3; if (!c[2]) r = TSIC_REF_YPLATE; end
      3'h2: i = TSIC_IN_BAT;
      3'h3: begin i = TSIC_IN_XP; d = 4'h6; end
      3'h4: begin i = TSIC_IN_YM; d = 4'h6; end
      3'h5: begin i = TSIC_IN_YP; d = 4'hc; if (!c[2]) r = TSIC_REF_XPLATE; end
      default: i = TSIC_IN_AUX;
    endcase
    return {d, i, r, c[2] && c[6:4] == 3'h2, c[6:4] == 3'h7};
  endfunction
  task automatic frame(input logic [7:0] c, input logic dup);
    logic [11:0] e, m;
    logic [10:0] x;
    int n;
    sample_data <= 12'($urandom);
    bus(1'b1, 4'h0, {24'h0, c}, q);
    if (dup) bus(1'b1, 4'h0, 32'h0000_00ff, q); // dropped while busy
    n = 0;
    q = 32'h0;
    while (q[1] !== 1'b1 && n < 300) begin
      bus(1'b0, 4'h4, 32'h0, q);
      n++;
    end
    e = c[3] ? sample_data : {sample_data[11:4], 4'h0};
    m = c[3] ? 12'hfff : 12'hff0;
    bus(1'b0, 4'h8, 32'h0, q);
    chk_word({20'h0, q[11:0] & m}, {20'h0, e & m});
    chk_word({20'h0, sho[13:2] & m}, {20'h0, e & m});
    chk_word({24'h0, shi[23:16]}, {24'h0, c | 8'h80});
    bus(1'b0, 4'h0, 32'h0, q);
    chk_word(q, {24'h0, c | 8'h80});
    chk_word({31'h0, int_ref_en_r}, {31'h0, c[1]});
    chk_word({31'h0, conv_power_r}, {31'h0, c[0]});
    x = exp_cfg(c);
    if (!c[2] && (c[6:4] == 3'h3 || c[6:4] == 3'h4)) x[3:2] = cap[3:2];
    chk_cfg(cap, x);
    chk_word({31'h0, (c[2] || x[10:7] == 4'h0) ? drv_cnt <= samp_cnt : drv_cnt > samp_cnt + 8}, 32'h1);
  endtask
  initial begin
    rst_b = 1'b0;
    touch_detected = 1'b0;
    sample_data = 12'h000;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    bad_count = 0;
    cmp_count = 0;
    void'($urandom(46));
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    bus(1'b0, 4'h6, 32'h0, q);
    chk_word(q, 32'h0000_0000);
    for (k = 0; k < 16; k++) begin
      b = {1'b1, k[2:0], 1'($urandom), ~k[3], 2'($urandom)};
      if (!b[2] && (b[6:4] == 3'h2 || b[6:4] == 3'h6)) b[6:4] = 3'h5;
      frame(b, 1'b0);
    end
    for (k = 0; k < 20; k++) begin
      b = 8'($urandom) | 8'h80;
      if (!b[2] && (b[6:4] == 3'h2 || b[6:4] == 3'h6)) b[6:4] = 3'h1;
      frame(b, k == 3);
    end
    frame(8'hd4, 1'b0);
    touch_detected <= 1'b1;
    repeat (10) @(posedge clk);
    chk_word({31'h0, link.pen_touch_irq_n_line}, 32'h0);
    bus(1'b0, 4'h4, 32'h0, q);
    chk_word({31'h0, q[2]}, 32'h1);
    touch_detected <= 1'b0;
    repeat (10) @(posedge clk);
    chk_word({31'h0, link.pen_touch_irq_n_line}, 32'h1);
    frame(8'hd5, 1'b0);
    touch_detected <= 1'b1;
    repeat (10) @(posedge clk);
    chk_word({31'h0, link.pen_touch_irq_n_line}, 32'h1);
    touch_detected <= 1'b0;
    wrap_up();
  end
endmodule

// file: tb/tsic_link_asserts.sv
// Purpose: concurrent checks on the touch link and the matrix outputs
// Assumes: clk 10 MHz, rst_b asynchronous active low
// Notes: link pins pass a sync in the device, so idle checks allow a few cycles to settle
module tsic_link_asserts (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cs_b,
  input wire logic dout,
  input wire logic busy,
  input wire logic pen_touch_irq_n_oe,
  input wire logic touch_detected,
  input wire logic [3:0] plate_drv_r,
  input wire tsic_pkg::tsic_in_type adc_in_r,
  input wire tsic_pkg::tsic_ref_type adc_ref_r,
  input wire logic bat_div_en_r,
  input wire logic sampling_r
);
  import tsic_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_idle;
    cs_b [*6];
  endsequence
  sequence s_busy_period;
    busy [*7] ##[1:2] !busy;
  endsequence
  property p_idle_quiet; s_idle |-> !dout && !busy; endproperty
  property p_idle_plates_off; s_idle ##1 cs_b [*2] |-> plate_drv_r == 4'h0; endproperty
  property p_no_touch_no_pen; (cs_b && !touch_detected) [*6] |-> !pen_touch_irq_n_oe; endproperty
  property p_busy_len; $rose(busy) |-> s_busy_period; endproperty
  property p_busy_masks_pen; busy |-> !pen_touch_irq_n_oe; endproperty
  property p_bat_in_sampling; bat_div_en_r |-> sampling_r && adc_in_r == TSIC_IN_BAT; endproperty
  property p_bat_no_drv; bat_div_en_r |-> plate_drv_r == 4'h0; endproperty
  property p_misc_no_drv;
    sampling_r && (adc_in_r == TSIC_IN_AUX || adc_in_r == TSIC_IN_TEMP) |-> plate_drv_r == 4'h0;
  endproperty
  property p_temp_int_ref; sampling_r && adc_in_r == TSIC_IN_TEMP |-> adc_ref_r == TSIC_REF_INT; endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("dout or busy active while deselected");
  a_idle_plates_off: assert property (p_idle_plates_off)
    else $error("plates driven outside a frame");
  a_no_touch_no_pen: assert property (p_no_touch_no_pen)
    else $error("pen request without touch");
  a_busy_len: assert property (p_busy_len)
    else $error("busy not one link period");
  a_busy_masks_pen: assert property (p_busy_masks_pen)
    else $error("pen request not masked in frame");
  a_bat_in_sampling: assert property (p_bat_in_sampling)
    else $error("battery divider on outside battery sampling");
  a_bat_no_drv: assert property (p_bat_no_drv)
    else $error("plates driven on battery channel");
  a_misc_no_drv: assert property (p_misc_no_drv)
    else $error("plates driven on aux or temperature");
  a_temp_int_ref: assert property (p_temp_int_ref)
    else $error("temperature not on internal reference");
endmodule
